// [core/ulsc_storage_check.sv]
// unit loop test storage check with AHB-Lite register slave
// Functional notes
// - td word checked only by zero test
// - stretcher set loads one into stage one
// - td shifting started by strobe 2 not sync
// - transfer pulse complements matching right-half bits
// - right-half bit ends zero when returned matches
// - error when any of 17 bits nonzero
// - zero strobe: ptp step 19, td gated 4
// - error at zero strobe sets master stop
// - stop-on-error: enable only while stop clear
// - otherwise enable held except reset and prime
// - 17 serial stages, parallel complement at end
// - loop path only ptp and td words
// - readout trigger ptp step 18, td 17
// - trigger sets transfer flop, gates strobe 3
// - readout pulse clears the transfer flop
// - td word odd parity, others even
// - td readout sets td control flop
// - gated strobe 1 clears it, sets parity
// - bit written between strobe 4 and 2
// - shift flop pulses strobe 2 to 3
// - no parallel transfer without readout pulse
// - readout coincides with end shift
// - ptp phase flop toggles at step 18
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`include "ulsc_defs.svh"
module ulsc_storage_check import ulsc_pkg::*; #(
   parameter int STROBE_CYC = `ULSC_STROBE_CYC
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        testDataPulse,
   input  wire logic        syncIn,
   output logic             strobeEnable,
   output logic             masterStop,
   output logic [16:0]      errorLamps
);
   localparam int W = `ULSC_WORD_BITS;

   function automatic ulsc_mode_t modeOf(input ulsc_sel_t s);
      if (s.sectionSelectTwo)
         modeOf = ULSC_TD;
      else if (s.sectionSelectOne)
         modeOf = ULSC_PTP;
      else if (s.sectionSelectSign)
         modeOf = ULSC_TTY;
      else
         modeOf = ULSC_NONE;
   endfunction

   logic [31:0]  ctrl_reg;
   logic [W-1:0] shift_reg;
   logic [W-1:0] obuf_reg;
   logic [4:0]   stepPtp_reg;
   logic [4:0]   stepTd_reg;
   logic [15:0]  div_reg;
   ulsc_phase_t  phase_reg;
   ulsc_strobe_t strobe;
   logic         stretch_reg;
   logic         shiftFf_reg;
   logic         xfer_reg;
   logic         tdCtrl_reg;
   logic         tdZero_reg;
   logic         phaseFlip_reg;
   logic         stop_reg;
   logic         enable_reg;
   logic [2:0]   dpSync_reg;
   logic [2:0]   snSync_reg;
   logic         dpStable_reg;
   logic         snStable_reg;
   logic         wrPend_reg;
   logic [7:0]   wrAddr_reg;
   ulsc_sel_t    sel;
   ulsc_mode_t   mode;
   logic         loopOn;
   logic         primePulse;
   logic         dataEdge;
   logic         readout;
   logic         trigger;
   logic         zeroStrobe;
   logic         errorCond;
   logic         tdParity;
   logic [W-1:0] shiftNext;
   logic         addrTake;
   ulsc_status_t status;

   // fields named one by one: the struct's first member is its top bit
   assign sel        = '{sectionSelectSign: ctrl_reg[`ULSC_CTRL_SIGN],
                         sectionSelectOne:  ctrl_reg[`ULSC_CTRL_ONE],
                         sectionSelectTwo:  ctrl_reg[`ULSC_CTRL_TWO]};
   assign mode       = modeOf(sel);
   assign loopOn     = ctrl_reg[`ULSC_CTRL_ON] &&
                       (mode == ULSC_PTP || mode == ULSC_TD);
   assign primePulse = wrPend_reg && wrAddr_reg == `ULSC_OFF_CTRL &&
                       hwdata[`ULSC_CTRL_PRIME];
   assign tdParity   = ctrl_reg[`ULSC_CTRL_PAR];

   // three-stage pin synchronisers; a change counts when 2 and 3 agree
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dpSync_reg   <= 3'h0;
         snSync_reg   <= 3'h0;
         dpStable_reg <= 1'b0;
         snStable_reg <= 1'b0;
      end else begin
         dpSync_reg <= {dpSync_reg[1:0], testDataPulse};
         snSync_reg <= {snSync_reg[1:0], syncIn};
         if (dpSync_reg[1] == dpSync_reg[2])
            dpStable_reg <= dpSync_reg[2];
         if (snSync_reg[1] == snSync_reg[2])
            snStable_reg <= snSync_reg[2];
      end
   end
   assign dataEdge = dpSync_reg[1] && dpSync_reg[2] && !dpStable_reg;

   // phase generator: four one-cycle strobes, 2.5 us apart
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_reg   <= 16'h0000;
         phase_reg <= PS1;
      end else if (primePulse) begin
         div_reg   <= 16'h0000;
         phase_reg <= PS1;
      end else if (enable_reg) begin
         if (div_reg == 16'(STROBE_CYC - 1)) begin
            div_reg <= 16'h0000;
            case (phase_reg)
               PS1: phase_reg <= PS2;
               PS2: phase_reg <= PS3;
               PS3: phase_reg <= PS4;
               PS4: phase_reg <= PS1;
               default: phase_reg <= PS1;
            endcase
         end else begin
            div_reg <= div_reg + 16'h0001;
         end
      end
   end
   always_comb begin
      strobe = '0;
      if (enable_reg && div_reg == 16'(STROBE_CYC - 1)) begin
         strobe.strobe1 = phase_reg == PS4;
         strobe.strobe2 = phase_reg == PS1;
         strobe.strobe3 = phase_reg == PS2;
         strobe.strobe4 = phase_reg == PS3;
      end
   end

   // step counters advance at strobe 4, one column per phase cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stepPtp_reg   <= 5'd1;
         stepTd_reg    <= 5'd1;
         phaseFlip_reg <= 1'b0;
      end else if (primePulse) begin
         stepPtp_reg   <= 5'd1;
         stepTd_reg    <= 5'd1;
         phaseFlip_reg <= 1'b0;
      end else if (strobe.strobe4 && loopOn) begin
         stepPtp_reg <= (stepPtp_reg == 5'(`ULSC_PTP_STEPS)) ?
                        5'd1 : stepPtp_reg + 5'd1;
         stepTd_reg  <= (stepTd_reg == 5'(`ULSC_TD_STEPS)) ?
                        5'd1 : stepTd_reg + 5'd1;
         if (mode == ULSC_PTP &&
             stepPtp_reg == 5'(`ULSC_PTP_XFER_STEP))
            phaseFlip_reg <= !phaseFlip_reg;
      end
   end

   // data stretcher open from strobe 4 to strobe 2
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         stretch_reg <= 1'b0;
      else if (primePulse || strobe.strobe3)
         stretch_reg <= 1'b0;
      else if (dataEdge && loopOn &&
               (phase_reg == PS4 || phase_reg == PS1))
         stretch_reg <= 1'b1;
   end

   // shift flop: start at strobe 2, end at strobe 3
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         shiftFf_reg <= 1'b0;
      else if (strobe.strobe3 || primePulse)
         shiftFf_reg <= 1'b0;
      else if (strobe.strobe2 && loopOn &&
               (mode == ULSC_PTP || !snStable_reg))
         shiftFf_reg <= 1'b1;
   end

   assign shiftNext = {shift_reg[W-2:0], stretch_reg};
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         shift_reg <= '0;
      else if (primePulse || readout)
         shift_reg <= '0;
      else if (strobe.strobe3 && shiftFf_reg)
         shift_reg <= shiftNext;
   end

   // readout trigger and transfer flop
   always_comb begin
      trigger = 1'b0;
      if (loopOn && strobe.strobe3 && !xfer_reg) begin
         if (mode == ULSC_PTP)
            trigger = stepPtp_reg == 5'(`ULSC_PTP_XFER_STEP);
         else
            trigger = stepTd_reg == 5'(`ULSC_TD_XFER_STEP) &&
                      !snStable_reg;
      end
   end
   assign readout = strobe.strobe3 && xfer_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         xfer_reg <= 1'b0;
      else if (readout || primePulse)
         xfer_reg <= 1'b0;
      else if (trigger)
         xfer_reg <= 1'b1;
   end

   // td control flop gates the next strobe 1
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tdCtrl_reg <= 1'b0;
         tdZero_reg <= 1'b0;
      end else if (primePulse) begin
         tdCtrl_reg <= 1'b0;
         tdZero_reg <= 1'b0;
      end else begin
         if (readout && mode == ULSC_TD)
            tdCtrl_reg <= 1'b1;
         else if (strobe.strobe1 && tdCtrl_reg)
            tdCtrl_reg <= 1'b0;
         if (readout && mode == ULSC_TD)
            tdZero_reg <= 1'b1;
         else if (strobe.strobe4)
            tdZero_reg <= 1'b0;
      end
   end

   // zero test over 16 right-half bits and parity
   assign errorCond = |obuf_reg;
   always_comb begin
      zeroStrobe = 1'b0;
      if (loopOn && strobe.strobe4) begin
         if (mode == ULSC_PTP)
            zeroStrobe = stepPtp_reg == 5'(`ULSC_PTP_ZERO_STEP);
         else
            zeroStrobe = tdZero_reg;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         stop_reg <= 1'b0;
      else if (zeroStrobe && errorCond)
         stop_reg <= 1'b1;
      else if (primePulse)
         stop_reg <= 1'b0;
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         enable_reg <= 1'b0;
      else if (ctrl_reg[`ULSC_CTRL_STOP])
         enable_reg <= !stop_reg && !primePulse &&
                       !(zeroStrobe && errorCond);
      else
         enable_reg <= !primePulse;
   end

   // AHB-Lite slave, zero wait states, always OKAY
   assign addrTake = hsel && htrans[1] && hready;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
      end else begin
         wrPend_reg <= addrTake && hwrite;
         if (addrTake)
            wrAddr_reg <= haddr[7:0];
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         ctrl_reg <= `ULSC_CTRL_RESET;
      else if (wrPend_reg && wrAddr_reg == `ULSC_OFF_CTRL)
         ctrl_reg <= {26'h0, hwdata[5:0]};
   end
   // output buffer: original word from software, complemented on readout
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         obuf_reg <= `ULSC_OBUF_RESET;
      else if (readout)
         obuf_reg <= obuf_reg ^ shiftNext;
      else if (strobe.strobe1 && tdCtrl_reg && tdParity)
         obuf_reg[W-1] <= 1'b1;
      else if (wrPend_reg && wrAddr_reg == `ULSC_OFF_OBUF)
         obuf_reg <= hwdata[W-1:0];
   end
   assign status = '{phaseFlip: phaseFlip_reg, tdControl: tdCtrl_reg,
                     testTransfer: xfer_reg, errorCond: errorCond,
                     strobeEnable: enable_reg, masterStop: stop_reg};
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (addrTake && !hwrite) begin
         case (haddr[7:0])
            `ULSC_OFF_CTRL:   hrdata <= ctrl_reg;
            `ULSC_OFF_STATUS: hrdata <= {26'h0, status};
            `ULSC_OFF_SHIFT:  hrdata <= {15'h0, shift_reg};
            `ULSC_OFF_OBUF:   hrdata <= {15'h0, obuf_reg};
            `ULSC_OFF_COUNT:  hrdata <= {19'h0, stepTd_reg, 3'h0,
                                         stepPtp_reg};
            default:          hrdata <= 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         strobeEnable <= 1'b0;
         masterStop   <= 1'b0;
         errorLamps   <= '0;
      end else begin
         strobeEnable <= enable_reg;
         masterStop   <= stop_reg;
         errorLamps   <= obuf_reg;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   ro_clears_xfer_a: assert property (readout |=> !xfer_reg)
      else $error("transfer flop not cleared by readout");
   trig_sets_xfer_a: assert property (trigger && !primePulse
      |=> xfer_reg)
      else $error("trigger did not set transfer flop");
   ro_complement_a: assert property (readout
      |=> obuf_reg == ($past(obuf_reg) ^ $past(shiftNext)))
      else $error("right half not complemented");
   zero_stop_a: assert property (zeroStrobe && errorCond
      |=> stop_reg)
      else $error("error at zero strobe did not stop");
   stop_halts_a: assert property (ctrl_reg[`ULSC_CTRL_STOP] && stop_reg
      |=> !enable_reg ##1 !strobeEnable)
      else $error("strobes still enabled after stop");
   // the edge that releases reset still leaves the enable at zero
   free_run_a: assert property (rstn && !ctrl_reg[`ULSC_CTRL_STOP]
      && !primePulse |=> enable_reg)
      else $error("enable dropped without stop-on-error");
   td_ctrl_gate_a: assert property (strobe.strobe1 && tdCtrl_reg
      && tdParity |=> !tdCtrl_reg && obuf_reg[W-1])
      else $error("td control strobe 1 mishandled");
   shift_win_a: assert property (shiftFf_reg |-> phase_reg == PS2)
      else $error("shift flop outside strobe 2 to 3");
   no_stray_xfer_a: assert property (!readout && !primePulse
      && !(wrPend_reg && wrAddr_reg == `ULSC_OFF_OBUF)
      && !(strobe.strobe1 && tdCtrl_reg && tdParity)
      |=> obuf_reg == $past(obuf_reg))
      else $error("output buffer changed without readout");
   tty_excluded_a: assert property (mode == ULSC_TTY |-> !readout)
      else $error("teleprinter word took loop path");
   cov_ptp_ro: cover property (readout && mode == ULSC_PTP);
   cov_td_ro: cover property (readout && mode == ULSC_TD);
   cov_stop: cover property (zeroStrobe && errorCond);
   cov_pass: cover property (zeroStrobe && !errorCond);
endmodule

// [core/ulsc_defs.svh]
// offsets, field positions, reset values and timing counts
`ifndef ULSC_DEFS_SVH
`define ULSC_DEFS_SVH
`define ULSC_CLK_NS        10
`define ULSC_STROBE_NS     2500
`define ULSC_STROBE_CYC    (`ULSC_STROBE_NS / `ULSC_CLK_NS)
`define ULSC_WORD_BITS     17
`define ULSC_PTP_STEPS     19
`define ULSC_TD_STEPS      17
`define ULSC_PTP_XFER_STEP 18
`define ULSC_PTP_ZERO_STEP 19
`define ULSC_TD_XFER_STEP  17
`define ULSC_OFF_CTRL      8'h00
`define ULSC_OFF_STATUS    8'h04
`define ULSC_OFF_SHIFT     8'h08
`define ULSC_OFF_OBUF      8'h0c
`define ULSC_OFF_COUNT     8'h10
`define ULSC_CTRL_SIGN     0
`define ULSC_CTRL_ONE      1
`define ULSC_CTRL_TWO      2
`define ULSC_CTRL_STOP     3
`define ULSC_CTRL_PAR      4
`define ULSC_CTRL_ON       5
`define ULSC_CTRL_PRIME    6
`define ULSC_CTRL_RESET    32'h0000_0000
`define ULSC_OBUF_RESET    17'h0_0000
`endif

// [core/ulsc_pkg.sv]
// types shared by the unit loop storage check
package ulsc_pkg;
   typedef enum logic [1:0] {ULSC_NONE, ULSC_PTP, ULSC_TD,
                             ULSC_TTY} ulsc_mode_t;
   typedef enum {PS1, PS2, PS3, PS4} ulsc_phase_t;
   typedef struct packed {
      logic sectionSelectSign;
      logic sectionSelectOne;
      logic sectionSelectTwo;
   } ulsc_sel_t;
   typedef struct packed {
      logic strobe1;
      logic strobe2;
      logic strobe3;
      logic strobe4;
   } ulsc_strobe_t;
   typedef struct packed {
      logic phaseFlip;
      logic tdControl;
      logic testTransfer;
      logic errorCond;
      logic strobeEnable;
      logic masterStop;
   } ulsc_status_t;
endpackage

// [bench/ulsc_far_model.sv]
// far side model: storage readout bit pulses and sync level
`timescale 1ns/100ps
module ulsc_far_model import ulsc_pkg::*; #(
   parameter int PERIOD = 32
) (
   input  wire logic clock,
   input  wire logic align,
   input  wire logic bitsOn,
   input  wire logic syncLevel,
   output logic      testDataPulse,
   output logic      syncIn
);
   int phaseCnt_reg;

   // free-running copy of the strobe cycle, phased by the bench
   always_ff @(posedge clock) begin
      if (align) begin
         phaseCnt_reg <= 0;
      end else begin
         phaseCnt_reg <= (phaseCnt_reg + 1) % PERIOD;
      end
   end

   // one bit per cycle, early in the strobe 4 to strobe 2 window
   assign testDataPulse = bitsOn && (phaseCnt_reg < 4);
   assign syncIn        = syncLevel;
endmodule

// [bench/test_ulsc_storage_check.sv]
// self-checking bench for the unit loop storage check
`timescale 1ns/100ps
`include "ulsc_defs.svh"
module test_ulsc_storage_check import ulsc_pkg::*;;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
   } ulsc_row_t;
   localparam int SCYC = 8;
   logic        clock, rstn, hsel, hwrite, align, bitsOn, syncLevel;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hready, hreadyout, hresp, testDataPulse, syncIn;
   logic        strobeEnable, masterStop;
   logic [16:0] errorLamps;
   int          fail_count, cmp_count;
   ulsc_row_t   rows [6];

   assign hready = hreadyout;
   always #5 clock = ~clock;

   ulsc_storage_check #(.STROBE_CYC(SCYC)) u_dut (
      .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .testDataPulse(testDataPulse), .syncIn(syncIn),
      .strobeEnable(strobeEnable), .masterStop(masterStop),
      .errorLamps(errorLamps));

   ulsc_far_model #(.PERIOD(4 * SCYC)) u_far (
      .clock(clock), .align(align), .bitsOn(bitsOn),
      .syncLevel(syncLevel), .testDataPulse(testDataPulse),
      .syncIn(syncIn));

   task automatic test_done();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic hang();
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      test_done();
   endtask

   // one single AHB-Lite transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      hsel   <= 1'b1;
      hwrite <= wr;
      hsize  <= 3'b010;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge clock);
            n++;
            if (n > 50) hang();
         end while (hreadyout !== 1'b1);
         if (p == 0) begin
            htrans <= 2'b00;
            hwdata <= wd;
         end
      end
      rd = hrdata;
   endtask

   task automatic waitStop(input int lim);
      int n;
      n = 0;
      while (masterStop !== 1'b1) begin
         @(negedge clock);
         n++;
         if (n > lim) hang();
      end
      @(posedge clock);
   endtask

   task automatic pollStep(input logic [4:0] val);
      int n;
      n = 0;
      do begin
         bus(1'b0, `ULSC_OFF_COUNT, 32'h0);
         n++;
         if (n > 400) hang();
      end while (rd[4:0] !== val);
   endtask

   // unit off and prime, load the buffer, then start the chosen mode
   task automatic setup(input logic [31:0] obuf, input logic [31:0] ctrl);
      bus(1'b1, `ULSC_OFF_CTRL, 32'h40);
      bus(1'b1, `ULSC_OFF_OBUF, obuf);
      bus(1'b1, `ULSC_OFF_CTRL, ctrl);
   endtask

   task automatic resetCheck();
      check({28'h0, hreadyout, masterStop, strobeEnable, hresp}, 32'h8,
            "reset outputs");
      check({15'h0, errorLamps}, 32'h0, "lamps in reset");
   endtask

   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      hsize = 3'b010;
      haddr = 32'h0;
      htrans = 2'b00;
      hwdata = 32'h0;
      align = 1'b0;
      bitsOn = 1'b0;
      syncLevel = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      rows = '{
         '{`ULSC_OFF_CTRL, 32'h1f, 32'h1f},
         '{`ULSC_OFF_CTRL, 32'h40, 32'h0},
         '{`ULSC_OFF_OBUF, 32'h1_2345, 32'h1_2345},
         '{`ULSC_OFF_SHIFT, 32'hffff, 32'h0},
         '{8'h20, 32'hffff_ffff, 32'h0},
         '{`ULSC_OFF_OBUF, 32'h0, 32'h0}};
      repeat (4) @(posedge clock);
      resetCheck();
      rstn <= 1'b1;
      @(posedge clock);
      bus(1'b0, `ULSC_OFF_CTRL, 32'h0);
      check(rd, `ULSC_CTRL_RESET, "ctrl reset");
      bus(1'b0, `ULSC_OFF_STATUS, 32'h0);
      check(rd & 32'h3, 32'h2, "enable after reset");
      foreach (rows[i]) begin
         bus(1'b1, rows[i].addr, rows[i].wdata);
         bus(1'b0, rows[i].addr, 32'h0);
         check(rd, rows[i].rexp, "register");
      end
      // wrong word with stop on error: halt
      setup(32'h4, 32'h2a);
      waitStop(1400);
      repeat (3) @(posedge clock);
      check({31'h0, strobeEnable}, 32'h0, "halted");
      check({15'h0, errorLamps}, 32'h4, "lamps");
      bus(1'b0, `ULSC_OFF_STATUS, 32'h0);
      check(rd & 32'h7, 32'h5, "status stop");
      setup(32'h0, 32'h2a);
      repeat (3) @(posedge clock);
      check({30'h0, masterStop, strobeEnable}, 32'h1, "primed");
      repeat (1300) @(posedge clock);
      check({31'h0, masterStop}, 32'h0, "clean word");
      // wrong word, stop switch open: keeps cycling
      setup(32'h8000, 32'h22);
      waitStop(1400);
      repeat (20) @(posedge clock);
      check({31'h0, strobeEnable}, 32'h1, "runs on");
      check({15'h0, errorLamps}, 32'h8000, "lamp on");
      // teleprinter class takes no loop path
      setup(32'h1, 32'h29);
      repeat (1300) @(posedge clock);
      check({31'h0, masterStop}, 32'h0, "no zero test");
      bus(1'b0, `ULSC_OFF_OBUF, 32'h0);
      check(rd, 32'h1, "buffer kept");
      // time division: nothing while sync, then forced parity
      syncLevel <= 1'b1;
      setup(32'h0, 32'h3c);
      repeat (1300) @(posedge clock);
      check({31'h0, masterStop}, 32'h0, "held by sync");
      syncLevel <= 1'b0;
      waitStop(2500);
      check({15'h0, errorLamps}, 32'h1_0000, "parity forced");
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      resetCheck();
      rstn <= 1'b1;
      @(posedge clock);
      // serial fill: ones enter stage 0 and move up
      setup(32'h0, 32'h22);
      pollStep(5'd19);
      pollStep(5'd1);
      align <= 1'b1;
      bitsOn <= 1'b1;
      @(posedge clock);
      align <= 1'b0;
      repeat (6 * 4 * SCYC) @(posedge clock);
      bus(1'b0, `ULSC_OFF_SHIFT, 32'h0);
      check({31'h0, (rd != 32'h0) && (((rd + 32'h1) & rd) == 32'h0)},
            32'h1, "serial fill");
      bitsOn <= 1'b0;
      test_done();
   end
endmodule
